// ---- hdl/sar_conv_clock.v ----
// internal conversion clock: free tick generator gated by a run request
`timescale 1ns/10ps
`default_nettype none
`include "sar_seq_defs.vh"
module sar_conv_clock (
  input  wire       clk_in,
  input  wire       arst_n_in,
  input  wire       ce_in,
  input  wire       run_in,
  output reg        tick_out
);
  localparam integer           LAST_I = `SAR_STEP_CYC - 1;
  localparam [`SAR_TICK_W-1:0] LAST   = LAST_I[`SAR_TICK_W-1:0];
  reg [`SAR_TICK_W-1:0] cnt_q;
  // stopped while idle so the oscillator draws nothing between conversions
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cnt_q    <= {`SAR_TICK_W{1'b0}};
      tick_out <= 1'b0;
    end else if (ce_in) begin
      if (!run_in) begin
        cnt_q    <= {`SAR_TICK_W{1'b0}};
        tick_out <= 1'b0;
      end else if (cnt_q == LAST) begin
        cnt_q    <= {`SAR_TICK_W{1'b0}};
        tick_out <= 1'b1;
      end else begin
        cnt_q    <= cnt_q + {{(`SAR_TICK_W-1){1'b0}}, 1'b1};
        tick_out <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- hdl/sar_conversion_sequencer.v ----
// successive-approximation conversion sequencer for an 18-bit differential converter
`timescale 1ns/10ps
`default_nettype none
`include "sar_seq_defs.vh"
module sar_conversion_sequencer (
  input  wire                  clk_in,
  input  wire                  arst_n_in,
  input  wire                  ce_in,
  input  wire                  convert_start_in,
  input  wire                  chain_select_input_in,
  input  wire                  cs_mode_in,
  input  wire                  comp_keep_in,
  input  wire                  over_range_in,
  input  wire                  under_range_in,
  output reg                   pos_sample_switch_out,
  output reg                   neg_sample_switch_out,
  output reg                   array_to_input_out,
  output reg  [`SAR_BITS-1:0]  pos_dac_ref_out,
  output reg  [`SAR_BITS-1:0]  neg_dac_ref_out,
  output reg                   acquiring_out,
  output reg                   powered_out,
  output reg  [`SAR_BITS-1:0]  result_out,
  output reg                   result_valid_out,
  output reg                   busy_ind_out
);
  // one-hot state codes, though each state decode here still compares all five bits of state_q
  localparam [4:0] S_ACQ   = 5'h01;
  localparam [4:0] S_OPEN  = 5'h02;
  localparam [4:0] S_ROUTE = 5'h04;
  localparam [4:0] S_TRIAL = 5'h08;
  localparam [4:0] S_DONE  = 5'h10;
  localparam integer LAST_BIT_I = `SAR_BITS - 1;
  localparam [4:0]   LAST_BIT   = LAST_BIT_I[4:0];

  reg  [4:0]           state_q;
  reg  [4:0]           bit_q;
  reg                  cnv_prev_q;
  reg  [`SAR_BITS-1:0] code_q;
  wire                 tick;
  wire                 running;
  wire                 cnv_rise;
  wire [`SAR_BITS-1:0] next_code;

  // offset-binary search code to two's complement: invert the sign bit
  function [`SAR_BITS-1:0] to_twos;
    input [`SAR_BITS-1:0] ob;
    begin
      to_twos = {~ob[`SAR_BITS-1], ob[`SAR_BITS-2:0]};
    end
  endfunction

  // bit index to the single array element it switches
  function [`SAR_BITS-1:0] onehot;
    input [4:0] idx;
    begin
      onehot = {{(`SAR_BITS-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  // one search step: drop the trial bit on overshoot, then try the next lower bit
  function [`SAR_BITS-1:0] trial_next;
    input [`SAR_BITS-1:0] cur;
    input [4:0]           idx;
    input                 keep;
    reg   [`SAR_BITS-1:0] kept;
    begin
      kept = keep ? cur : (cur & ~onehot(idx));
      if (idx == 5'h00)
        trial_next = kept;
      else
        trial_next = kept | onehot(idx - 5'h01);
    end
  endfunction

  // range flags override the search so an out-of-span input clamps instead of wrapping
  function [`SAR_BITS-1:0] final_code;
    input [`SAR_BITS-1:0] ob;
    input                 over;
    input                 under;
    begin
      if (over)
        final_code = `SAR_CODE_POS_MAX;
      else if (under)
        final_code = `SAR_CODE_NEG_MAX;
      else
        final_code = to_twos(ob);
    end
  endfunction

  // chip-select mode only; the chain-mode busy option is left to the readout side
  function busy_enable;
    input cs_mode;
    input sel;
    input convert_start;
    begin
      busy_enable = cs_mode & (~sel | ~convert_start);
    end
  endfunction

  assign running   = (state_q != S_ACQ);
  // cleared by reset, so a level already high at release counts as a fresh edge
  assign cnv_rise  = convert_start_in & ~cnv_prev_q;
  // only looked at on a tick, so the comparator has a whole step to settle
  assign next_code = trial_next(code_q, bit_q, comp_keep_in);

  sar_conv_clock u_clk (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .ce_in     (ce_in),
    .run_in    (running),
    .tick_out  (tick)
  );

  // every output is a flop, so the switch drivers never see a decode glitch
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      // reset parks the converter in acquisition with the switches closed
      state_q               <= S_ACQ;
      bit_q                 <= LAST_BIT;
      cnv_prev_q            <= 1'b0;
      code_q                <= `SAR_CODE_ZERO;
      pos_sample_switch_out <= 1'b1;
      neg_sample_switch_out <= 1'b1;
      array_to_input_out    <= 1'b1;
      pos_dac_ref_out       <= {`SAR_BITS{1'b0}};
      neg_dac_ref_out       <= {`SAR_BITS{1'b0}};
      acquiring_out         <= 1'b1;
      powered_out           <= 1'b0;
      result_out            <= `SAR_CODE_ZERO;
      result_valid_out      <= 1'b0;
      busy_ind_out          <= 1'b0;
    end else if (ce_in) begin
      // ce low freezes every register here and in the tick counter alike
      cnv_prev_q       <= convert_start_in;
      result_valid_out <= 1'b0;
      case (state_q)
        S_ACQ: begin
          if (cnv_rise) begin
            // a stale busy from the last result is withdrawn as the new sample is held
            pos_sample_switch_out <= 1'b0;
            neg_sample_switch_out <= 1'b0;
            acquiring_out         <= 1'b0;
            powered_out           <= 1'b1;
            busy_ind_out          <= 1'b0;
            state_q               <= S_OPEN;
          end
        end
        S_OPEN: begin
          // arrays leave the inputs only a conversion tick after the switches open
          if (tick) begin
            array_to_input_out <= 1'b0;
            state_q            <= S_ROUTE;
          end
        end
        S_ROUTE: begin
          // the MSB trial goes out on both arrays together, mirrored
          if (tick) begin
            bit_q           <= LAST_BIT;
            code_q          <= onehot(LAST_BIT);
            pos_dac_ref_out <= onehot(LAST_BIT);
            neg_dac_ref_out <= ~onehot(LAST_BIT);
            state_q         <= S_TRIAL;
          end
        end
        S_TRIAL: begin
          // convert_start is not looked at here, so the search always finishes
          if (tick) begin
            code_q <= next_code;
            if (bit_q == 5'h00) begin
              state_q <= S_DONE;
            end else begin
              pos_dac_ref_out <= next_code;
              neg_dac_ref_out <= ~next_code;
              bit_q           <= bit_q - 5'h01;
            end
          end
        end
        S_DONE: begin
          // code and return to acquisition share one cycle, so tracking restarts at once
          result_out            <= final_code(code_q, over_range_in, under_range_in);
          result_valid_out      <= 1'b1;
          busy_ind_out          <= busy_enable(cs_mode_in, chain_select_input_in, convert_start_in);
          pos_sample_switch_out <= 1'b1;
          neg_sample_switch_out <= 1'b1;
          array_to_input_out    <= 1'b1;
          pos_dac_ref_out       <= {`SAR_BITS{1'b0}};
          neg_dac_ref_out       <= {`SAR_BITS{1'b0}};
          acquiring_out         <= 1'b1;
          powered_out           <= 1'b0;
          state_q               <= S_ACQ;
        end
        default: begin
          // a corrupted state drops back to a safe acquisition with the arrays parked
          pos_sample_switch_out <= 1'b1;
          neg_sample_switch_out <= 1'b1;
          array_to_input_out    <= 1'b1;
          pos_dac_ref_out       <= {`SAR_BITS{1'b0}};
          neg_dac_ref_out       <= {`SAR_BITS{1'b0}};
          acquiring_out         <= 1'b1;
          powered_out           <= 1'b0;
          state_q               <= S_ACQ;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hdl/sar_seq_defs.vh ----
// timing counts, widths and code constants for the conversion sequencer
`ifndef SAR_SEQ_DEFS_VH
`define SAR_SEQ_DEFS_VH
`define SAR_BITS          18
`define SAR_CODE_ZERO     18'h00000
`define SAR_CODE_POS_MAX  18'h1ffff
`define SAR_CODE_NEG_MAX  18'h20000
`define SAR_CLK_NS        5
// conversion clock period and settle times, in ns
`define SAR_STEP_NS       20
`define SAR_OPEN_NS       10
`define SAR_ROUTE_NS      10
// cycle counts derived from the times above, least times rounded up
`define SAR_STEP_CYC      ((`SAR_STEP_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_OPEN_CYC      ((`SAR_OPEN_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_ROUTE_CYC     ((`SAR_ROUTE_NS + `SAR_CLK_NS - 1) / `SAR_CLK_NS)
`define SAR_TICK_W        4
`endif

// ---- testbench/sar_comp_model.sv ----
// comparator and dac array model
`timescale 1ns/10ps
`default_nettype none
module sar_comp_model (
  input  wire logic [17:0] dac_in,
  input  wire logic [17:0] code_in,
  output logic             keep_out
);
  // the array works in offset form, so the sign bit is flipped
  assign keep_out = dac_in <= (code_in ^ 18'h20000);
endmodule
`default_nettype wire

// ---- testbench/sar_seq_checker.sv ----
// sequencer order, timing and coding properties
`timescale 1ns/10ps
`default_nettype none
module sar_seq_checker (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        ce_in,
  input wire logic        convert_start_in,
  input wire logic        chain_select_input_in,
  input wire logic        cs_mode_in,
  input wire logic        over_range_in,
  input wire logic        under_range_in,
  input wire logic        pos_sample_switch_out,
  input wire logic        neg_sample_switch_out,
  input wire logic        array_to_input_out,
  input wire logic        acquiring_out,
  input wire logic        powered_out,
  input wire logic        result_valid_out,
  input wire logic        busy_ind_out,
  input wire logic [17:0] pos_dac_ref_out,
  input wire logic [17:0] neg_dac_ref_out,
  input wire logic [17:0] result_out
);
  logic prev_q;
  wire start = ce_in && acquiring_out && convert_start_in && !prev_q;
  always_ff @(posedge clk_in or negedge arst_n_in)
    if (!arst_n_in) prev_q <= 1'b0;
    else if (ce_in) prev_q <= convert_start_in;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_start; start |=> !pos_sample_switch_out && !neg_sample_switch_out && powered_out; endproperty
  a_start: assert property (p_start) else $error("start");
  property p_order; $fell(array_to_input_out) |-> !$past(pos_sample_switch_out) && !neg_sample_switch_out; endproperty
  a_order: assert property (p_order) else $error("order");
  property p_msb; $fell(array_to_input_out) |-> ##4 pos_dac_ref_out == 18'h20000; endproperty
  a_msb: assert property (p_msb) else $error("msb");
  property p_arr; pos_dac_ref_out != 18'h0 |-> neg_dac_ref_out == ~pos_dac_ref_out; endproperty
  a_arr: assert property (p_arr) else $error("arrays");
  property p_lat; start |-> ##83 result_valid_out; endproperty
  a_lat: assert property (p_lat) else $error("latency");
  property p_idle;
    result_valid_out |-> acquiring_out && !powered_out && pos_sample_switch_out && array_to_input_out;
  endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_ovr; result_valid_out && $past(over_range_in) |-> result_out == 18'h1ffff; endproperty
  a_ovr: assert property (p_ovr) else $error("over");
  property p_und;
    result_valid_out && !$past(over_range_in) && $past(under_range_in) |-> result_out == 18'h20000;
  endproperty
  a_und: assert property (p_und) else $error("under");
  property p_busy; result_valid_out |-> busy_ind_out ==
    ($past(cs_mode_in) && !($past(chain_select_input_in) && $past(convert_start_in))); endproperty
  a_busy: assert property (p_busy) else $error("busy");
  c_ovr: cover property (result_valid_out && result_out == 18'h1ffff);
  c_und: cover property (result_valid_out && result_out == 18'h20000);
  c_busy: cover property (busy_ind_out);
endmodule
bind sar_conversion_sequencer sar_seq_checker u_sar_seq_checker (
  .clk_in                (clk_in),
  .arst_n_in             (arst_n_in),
  .ce_in                 (ce_in),
  .convert_start_in      (convert_start_in),
  .chain_select_input_in (chain_select_input_in),
  .cs_mode_in            (cs_mode_in),
  .over_range_in         (over_range_in),
  .under_range_in        (under_range_in),
  .pos_sample_switch_out (pos_sample_switch_out),
  .neg_sample_switch_out (neg_sample_switch_out),
  .array_to_input_out    (array_to_input_out),
  .acquiring_out         (acquiring_out),
  .powered_out           (powered_out),
  .result_valid_out      (result_valid_out),
  .busy_ind_out          (busy_ind_out),
  .pos_dac_ref_out       (pos_dac_ref_out),
  .neg_dac_ref_out       (neg_dac_ref_out),
  .result_out            (result_out)
);
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_in = 0, arst_n_in = 0, ce_in = 1, convert_start_in = 0, chain_select_input_in = 0;
  logic cs_mode_in = 0, over_range_in = 0, under_range_in = 0, comp_keep_in;
  logic pos_sample_switch_out, neg_sample_switch_out, array_to_input_out, acquiring_out, powered_out;
  logic result_valid_out, busy_ind_out;
  logic [17:0] pos_dac_ref_out, neg_dac_ref_out, result_out, code = 0;
  logic [17:0] corner [6] = '{18'h0, 18'h1, 18'h3ffff, 18'h1ffff, 18'h20000, 18'h20001};
  int fail_count = 0, compares = 0;
  always #2.5 clk_in = ~clk_in;
  sar_conversion_sequencer u_sar_conversion_sequencer (
    .clk_in                (clk_in),
    .arst_n_in             (arst_n_in),
    .ce_in                 (ce_in),
    .convert_start_in      (convert_start_in),
    .chain_select_input_in (chain_select_input_in),
    .cs_mode_in            (cs_mode_in),
    .comp_keep_in          (comp_keep_in),
    .over_range_in         (over_range_in),
    .under_range_in        (under_range_in),
    .pos_sample_switch_out (pos_sample_switch_out),
    .neg_sample_switch_out (neg_sample_switch_out),
    .array_to_input_out    (array_to_input_out),
    .pos_dac_ref_out       (pos_dac_ref_out),
    .neg_dac_ref_out       (neg_dac_ref_out),
    .acquiring_out         (acquiring_out),
    .powered_out           (powered_out),
    .result_out            (result_out),
    .result_valid_out      (result_valid_out),
    .busy_ind_out          (busy_ind_out)
  );
  sar_comp_model u_sar_comp_model (.dac_in(pos_dac_ref_out), .code_in(code), .keep_out(comp_keep_in));
  function automatic logic [17:0] exp_code(input logic [17:0] c, input logic o, u);
    return o ? 18'h1ffff : u ? 18'h20000 : c;
  endfunction
  task automatic chk(input logic [17:0] got, exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    if (fail_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // k is the convert level held after the start edge
  task automatic conv(input logic [17:0] c, input logic o, u, k);
    int n = 0;
    @(posedge clk_in);
    code <= c;
    over_range_in <= o;
    under_range_in <= u;
    convert_start_in <= 1'b0;
    chain_select_input_in <= 1'($urandom);
    cs_mode_in <= 1'($urandom);
    @(posedge clk_in);
    convert_start_in <= 1'b1;
    @(posedge clk_in);
    convert_start_in <= k;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (result_valid_out !== 1'b1 && n < 200);
    chk(result_out, exp_code(c, o, u));
    chk({17'h0, busy_ind_out}, {17'h0, cs_mode_in & ~(chain_select_input_in & k)});
    chk({17'h0, result_valid_out}, 18'h00001);
    chk(18'(n), 18'h00052);
  endtask
  initial begin
    void'($urandom(31022));
    repeat (5) @(posedge clk_in);
    arst_n_in <= 1'b1;
    foreach (corner[i]) conv(corner[i], 1'b0, 1'b0, i[0]);
    conv(18'h0, 1'b1, 1'b0, 1'b0);
    conv(18'h0, 1'b0, 1'b1, 1'b1);
    conv(18'h3ffff, 1'b1, 1'b1, 1'b0);
    repeat (20) conv(18'($urandom), 1'b0, 1'b0, 1'($urandom));
    final_report;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    final_report;
  end
endmodule
`default_nettype wire
